// >>> hw/sfl_params.svh
`ifndef SFL_PARAMS_SVH
`define SFL_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SFL_OFS_CTRL      8'h00
`define SFL_OFS_INI_SET   8'h04
`define SFL_OFS_INI_CLR   8'h08
`define SFL_OFS_FIN_SET   8'h0C
`define SFL_OFS_FIN_CLR   8'h10
`define SFL_OFS_QMAX      8'h14
`define SFL_OFS_DCAP      8'h18
`define SFL_OFS_URATE     8'h1C
`define SFL_OFS_TGAIN     8'h20
`define SFL_OFS_EFF       8'h24
`define SFL_OFS_STATUS    8'h28
`define SFL_OFS_RESULT    8'h2C
`define SFL_OFS_NOMINAL   8'h30
`define SFL_OFS_LOAD      8'h34
`define SFL_OFS_IRQ_STAT  8'h38
`define SFL_OFS_IRQ_CLR   8'h3C
`define SFL_OFS_IRQ_EN    8'h40

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SFL_CTRL_MODE_BIT  0
`define SFL_CTRL_SEL_LSB   4
`define SFL_CTRL_HOLD_BIT  8
`define SFL_ST_FLAG1_BIT   0
`define SFL_ST_FLAGF_BIT   1
`define SFL_ST_MODE_BIT    2
`define SFL_ST_DSG_BIT     3
`define SFL_ST_SOC_LSB     8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SFL_RST_LOAD_MODE  1'b0
`define SFL_RST_LOAD_SEL   3'h1
`define SFL_RST_INI_SET    16'h0096
`define SFL_RST_INI_CLR    16'h00AF
`define SFL_RST_FIN_SET    16'h004B
`define SFL_RST_FIN_CLR    16'h0064
`define SFL_RST_QMAX       16'h03E8
`define SFL_RST_DCAP       16'h03E8
`define SFL_RST_EFF        32'hFFFF_FFFF

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SFL_CLK_HZ         10_000_000
`define SFL_TICK_S         1
`define SFL_SEC_CYCLES     (`SFL_CLK_HZ * `SFL_TICK_S)
`define SFL_LPF_TAU_S      14
`define SFL_LPF_K          (256 / `SFL_LPF_TAU_S)

`endif

// >>> hw/sfl_pkg.sv
package sfl_pkg;

    // ------------------------------------------------------------
    // Load model selector values
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SFL_SEL_LAST_RUN = 3'h0,
        SFL_SEL_PRESENT  = 3'h1,
        SFL_SEL_AVG      = 3'h2,
        SFL_SEL_FILTERED = 3'h3,
        SFL_SEL_CAP_DIV5 = 3'h4,
        SFL_SEL_USER     = 3'h6
    } sfl_sel_t;

    // ------------------------------------------------------------
    // Complete state of the gauge block
    // ------------------------------------------------------------
    typedef struct packed {
        logic               ack;
        logic [31:0]        rdata;
        logic               load_mode;
        logic [2:0]         load_sel;
        logic               hold_en;
        logic signed [15:0] ini_set;
        logic signed [15:0] ini_clr;
        logic signed [15:0] fin_set;
        logic signed [15:0] fin_clr;
        logic [15:0]        qmax;
        logic [15:0]        dcap;
        logic [15:0]        urate;
        logic [7:0]         tgain;
        logic [31:0]        eff;
        logic signed [15:0] nom_rem;
        logic signed [15:0] rem;
        logic [15:0]        full;
        logic [7:0]         soc;
        logic               flag1;
        logic               flagf;
        logic               dsg;
        logic [31:0]        cyc_sum;
        logic [15:0]        cyc_cnt;
        logic [15:0]        last_avg;
        logic               last_ok;
        logic [15:0]        lpf;
        logic [15:0]        rate;
        logic [23:0]        tick_cnt;
        logic [1:0]         upd;
        logic [2:0]         irq_st;
        logic [2:0]         irq_en;
    } sfl_state_t;

endpackage

// >>> hw/sfl_top.sv
//
// Contract
// - Set initial flag below its set threshold
// - Clear initial flag above its clear threshold
// - Set final flag below its set threshold
// - Final set threshold -1 disables the set
// - Clear final flag above clear, if set
// - Hold option freezes rising SOC during discharge
// - Load mode 0 current, 1 power, default 0; the bit is only stored and read back, the load model never uses it
// - Status bit mirrors load mode
// - Selector 0 last run, 1 present average
// - No last run: use present average
// - Selector 2 average, 3 filtered 14 s
// - Selector 4 capacity/5, 6 user rate
// - Full result is load-compensated deliverable charge
// - Provide uncompensated remaining and full too
// - Integrate sense charge both directions
// - Four efficiency factors correct charging
//
`timescale 1ns/1ps
`include "sfl_params.svh"

module sfl_top
    import sfl_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = `SFL_SEC_CYCLES
) (
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire logic [7:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output logic [31:0]             avs_readdata,
    output logic                    avs_waitrequest,
    input  wire logic               cc_valid,
    input  wire logic signed [15:0] cc_charge,
    input  wire logic signed [15:0] avg_current,
    output logic                    initial_low_charge_flag,
    output logic                    final_low_charge_flag,
    output logic                    irq
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] sfl_div(input logic [31:0] n, input logic [15:0] d);
        logic [32:0] r;
        logic [31:0] q;
        r = '0;
        q = n;
        for (int i = 0; i < 32; i++) begin
            r = {r[31:0], q[31]};
            q = {q[30:0], 1'b0};
            if (r >= {17'h0_0000, d}) begin
                r = r - {17'h0_0000, d};
                q[0] = 1'b1;
            end
        end
        if (d == 16'h0000) begin
            return 16'h0000;
        end
        return (q > 32'h0000_FFFF) ? 16'hFFFF : q[15:0];
    endfunction

    function automatic logic [31:0] sfl_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] be);
        logic [31:0] v;
        v = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                v[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return v;
    endfunction

    localparam logic signed [15:0] DISABLE_SET = 16'hFFFF;
    localparam logic [23:0]        TICK_LAST   = 24'(SEC_CYCLES - 1);
    localparam logic signed [16:0] LPF_K       = 17'(`SFL_LPF_K);

    sfl_state_t s_q;
    sfl_state_t s_d;

    logic               req;
    logic               wr_go;
    logic               tick;
    logic               dsg_now;
    logic [15:0]        abs_avg;
    logic [15:0]        pres_avg;
    logic [15:0]        rate_sel;
    logic [23:0]        unusable;
    logic signed [17:0] rem_calc;
    logic signed [17:0] full_calc;
    logic [15:0]        soc_calc;
    logic [7:0]         eff_sel;
    logic signed [23:0] chg_scaled;
    logic signed [17:0] nom_calc;
    logic signed [16:0] lpf_err;
    logic signed [33:0] lpf_step;
    logic [31:0]        ctrl_word;
    logic [2:0]         irq_evt;

    assign req     = avs_read | avs_write;
    assign wr_go   = avs_write & s_q.ack;
    assign tick    = (s_q.tick_cnt == TICK_LAST);
    assign dsg_now = avg_current < 0;
    assign abs_avg = dsg_now ? 16'(-avg_current) : 16'(avg_current);
    assign ctrl_word = {23'h00_0000, s_q.hold_en, 1'b0, s_q.load_sel, 3'h0, s_q.load_mode};

    // ------------------------------------------------------------
    // Load model and compensated results
    // ------------------------------------------------------------
    always_comb begin
        pres_avg = (s_q.cyc_cnt == 16'h0000) ? abs_avg : sfl_div(s_q.cyc_sum, s_q.cyc_cnt);
        case (s_q.load_sel)
            SFL_SEL_LAST_RUN: rate_sel = s_q.last_ok ? s_q.last_avg : pres_avg;
            SFL_SEL_PRESENT:  rate_sel = pres_avg;
            SFL_SEL_AVG:      rate_sel = abs_avg;
            SFL_SEL_FILTERED: rate_sel = s_q.lpf;
            SFL_SEL_CAP_DIV5: rate_sel = s_q.dcap / 16'd5;
            SFL_SEL_USER:     rate_sel = s_q.urate;
            default:          rate_sel = pres_avg;
        endcase
        unusable  = (24'(s_q.rate) * 24'(s_q.tgain)) >> 8;
        full_calc = $signed({2'b00, s_q.qmax}) - $signed({2'b00, unusable[15:0]});
        if (unusable[23:16] != 8'h00 || full_calc < 0) begin
            full_calc = '0;
        end
        rem_calc = 18'(s_q.nom_rem) - $signed({2'b00, unusable[15:0]});
        if (unusable[23:16] != 8'h00 || rem_calc < 0) begin
            rem_calc = '0;
        end
        soc_calc = sfl_div(32'(s_q.rem) * 32'd100, s_q.full);
        if (soc_calc > 16'd100) begin
            soc_calc = 16'd100;
        end
    end

    // ------------------------------------------------------------
    // Charge integration with efficiency correction
    // ------------------------------------------------------------
    always_comb begin
        if (s_q.soc < 8'd25) begin
            eff_sel = s_q.eff[7:0];
        end else if (s_q.soc < 8'd50) begin
            eff_sel = s_q.eff[15:8];
        end else if (s_q.soc < 8'd75) begin
            eff_sel = s_q.eff[23:16];
        end else begin
            eff_sel = s_q.eff[31:24];
        end
        // Charging loses heat: only positive charge is scaled down
        chg_scaled = 24'(cc_charge);
        if (cc_charge > 0) begin
            chg_scaled = (24'(cc_charge) * $signed({16'h0000, eff_sel})) >>> 8;
        end
        nom_calc = 18'(s_q.nom_rem) + 18'(chg_scaled);
        if (nom_calc < 0) begin
            nom_calc = '0;
        end else if (nom_calc > $signed({2'b00, s_q.qmax})) begin
            nom_calc = $signed({2'b00, s_q.qmax});
        end
        lpf_err  = $signed({1'b0, abs_avg}) - $signed({1'b0, s_q.lpf});
        lpf_step = (34'(lpf_err) * 34'(LPF_K)) >>> 8;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        irq_evt = 3'b000;
        s_d.ack = req & ~s_q.ack;
        s_d.tick_cnt = tick ? 24'h00_0000 : s_q.tick_cnt + 24'h00_0001;
        s_d.rate = rate_sel;
        s_d.full = full_calc[15:0];
        s_d.rem  = rem_calc[15:0];
        s_d.upd  = {s_q.upd[0], cc_valid};

        if (req & ~s_q.ack) begin
            case (avs_address)
                `SFL_OFS_CTRL:     s_d.rdata = ctrl_word;
                `SFL_OFS_INI_SET:  s_d.rdata = {16'h0000, s_q.ini_set};
                `SFL_OFS_INI_CLR:  s_d.rdata = {16'h0000, s_q.ini_clr};
                `SFL_OFS_FIN_SET:  s_d.rdata = {16'h0000, s_q.fin_set};
                `SFL_OFS_FIN_CLR:  s_d.rdata = {16'h0000, s_q.fin_clr};
                `SFL_OFS_QMAX:     s_d.rdata = {16'h0000, s_q.qmax};
                `SFL_OFS_DCAP:     s_d.rdata = {16'h0000, s_q.dcap};
                `SFL_OFS_URATE:    s_d.rdata = {16'h0000, s_q.urate};
                `SFL_OFS_TGAIN:    s_d.rdata = {24'h00_0000, s_q.tgain};
                `SFL_OFS_EFF:      s_d.rdata = s_q.eff;
                `SFL_OFS_STATUS:   s_d.rdata = {16'h0000, s_q.soc, 4'h0, s_q.dsg, s_q.load_mode,
                                                s_q.flagf, s_q.flag1};
                `SFL_OFS_RESULT:   s_d.rdata = {s_q.full, s_q.rem};
                `SFL_OFS_NOMINAL:  s_d.rdata = {s_q.qmax, s_q.nom_rem};
                `SFL_OFS_LOAD:     s_d.rdata = {16'h0000, s_q.rate};
                `SFL_OFS_IRQ_STAT: s_d.rdata = {29'h0000_0000, s_q.irq_st};
                `SFL_OFS_IRQ_EN:   s_d.rdata = {29'h0000_0000, s_q.irq_en};
                default:           s_d.rdata = 32'h0000_0000;
            endcase
        end

        if (wr_go) begin
            case (avs_address)
                `SFL_OFS_CTRL: begin
                    s_d.load_mode = avs_byteenable[0] ? avs_writedata[`SFL_CTRL_MODE_BIT] : s_q.load_mode;
                    s_d.load_sel  = avs_byteenable[0] ? avs_writedata[`SFL_CTRL_SEL_LSB +: 3] : s_q.load_sel;
                    s_d.hold_en   = avs_byteenable[1] ? avs_writedata[`SFL_CTRL_HOLD_BIT] : s_q.hold_en;
                end
                `SFL_OFS_INI_SET:  s_d.ini_set = 16'(sfl_merge({16'h0000, s_q.ini_set}, avs_writedata, avs_byteenable));
                `SFL_OFS_INI_CLR:  s_d.ini_clr = 16'(sfl_merge({16'h0000, s_q.ini_clr}, avs_writedata, avs_byteenable));
                `SFL_OFS_FIN_SET:  s_d.fin_set = 16'(sfl_merge({16'h0000, s_q.fin_set}, avs_writedata, avs_byteenable));
                `SFL_OFS_FIN_CLR:  s_d.fin_clr = 16'(sfl_merge({16'h0000, s_q.fin_clr}, avs_writedata, avs_byteenable));
                `SFL_OFS_QMAX:     s_d.qmax  = 16'(sfl_merge({16'h0000, s_q.qmax}, avs_writedata, avs_byteenable));
                `SFL_OFS_DCAP:     s_d.dcap  = 16'(sfl_merge({16'h0000, s_q.dcap}, avs_writedata, avs_byteenable));
                `SFL_OFS_URATE:    s_d.urate = 16'(sfl_merge({16'h0000, s_q.urate}, avs_writedata, avs_byteenable));
                `SFL_OFS_TGAIN:    s_d.tgain = avs_byteenable[0] ? avs_writedata[7:0] : s_q.tgain;
                `SFL_OFS_EFF:      s_d.eff   = sfl_merge(s_q.eff, avs_writedata, avs_byteenable);
                `SFL_OFS_IRQ_EN:   s_d.irq_en = avs_byteenable[0] ? avs_writedata[2:0] : s_q.irq_en;
                default: begin
                end
            endcase
        end

        if (cc_valid) begin
            s_d.nom_rem = nom_calc[15:0];
        end

        // SOC follows the result unless a rise is held during discharge
        if (!(s_q.hold_en && s_q.dsg && soc_calc[7:0] > s_q.soc)) begin
            s_d.soc = soc_calc[7:0];
        end

        // Flags are evaluated once the new remaining value is registered
        if (s_q.upd[1]) begin
            if (s_q.rem < s_q.ini_set) begin
                s_d.flag1 = 1'b1;
                irq_evt[0] = ~s_q.flag1;
            end else if (s_q.rem > s_q.ini_clr) begin
                s_d.flag1 = 1'b0;
            end
            if (s_q.rem < s_q.fin_set && s_q.fin_set != DISABLE_SET) begin
                s_d.flagf = 1'b1;
                irq_evt[1] = ~s_q.flagf;
            end else if (s_q.flagf && s_q.rem > s_q.fin_clr) begin
                s_d.flagf = 1'b0;
            end
        end

        // Discharge cycle bookkeeping
        s_d.dsg = dsg_now;
        if (dsg_now && !s_q.dsg) begin
            s_d.cyc_sum = 32'h0000_0000;
            s_d.cyc_cnt = 16'h0000;
        end else if (dsg_now && tick && s_q.cyc_cnt != 16'hFFFF) begin
            s_d.cyc_sum = s_q.cyc_sum + 32'(abs_avg);
            s_d.cyc_cnt = s_q.cyc_cnt + 16'h0001;
        end
        if (!dsg_now && s_q.dsg && s_q.cyc_cnt != 16'h0000) begin
            s_d.last_avg = pres_avg;
            s_d.last_ok  = 1'b1;
            irq_evt[2]   = 1'b1;
        end
        if (tick) begin
            s_d.lpf = s_q.lpf + lpf_step[15:0];
        end

        // Event set wins over a clear in the same cycle
        if (wr_go && avs_address == `SFL_OFS_IRQ_CLR && avs_byteenable[0]) begin
            s_d.irq_st = s_q.irq_st & ~avs_writedata[2:0];
        end
        s_d.irq_st = s_d.irq_st | irq_evt;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q           <= '0;
            s_q.load_mode <= `SFL_RST_LOAD_MODE;
            s_q.load_sel  <= `SFL_RST_LOAD_SEL;
            s_q.ini_set   <= `SFL_RST_INI_SET;
            s_q.ini_clr   <= `SFL_RST_INI_CLR;
            s_q.fin_set   <= `SFL_RST_FIN_SET;
            s_q.fin_clr   <= `SFL_RST_FIN_CLR;
            s_q.qmax      <= `SFL_RST_QMAX;
            s_q.dcap      <= `SFL_RST_DCAP;
            s_q.eff       <= `SFL_RST_EFF;
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_readdata            = s_q.rdata;
    assign avs_waitrequest         = req & ~s_q.ack;
    assign initial_low_charge_flag = s_q.flag1;
    assign final_low_charge_flag   = s_q.flagf;
    assign irq                     = |(s_q.irq_st & s_q.irq_en);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_flag1_set;
        @(posedge clk) disable iff (sys_rst)
        s_q.upd[1] && s_q.rem < s_q.ini_set |=> s_q.flag1;
    endproperty
    a_flag1_set: assert property (p_flag1_set) else $error("initial flag not set");

    property p_flag1_clr;
        @(posedge clk) disable iff (sys_rst)
        $fell(s_q.flag1) |-> $past(s_q.rem) > $past(s_q.ini_clr);
    endproperty
    a_flag1_clr: assert property (p_flag1_clr) else $error("initial flag cleared early");

    property p_flagf_set;
        @(posedge clk) disable iff (sys_rst)
        s_q.upd[1] && s_q.rem < s_q.fin_set && s_q.fin_set != DISABLE_SET |=> s_q.flagf;
    endproperty
    a_flagf_set: assert property (p_flagf_set) else $error("final flag not set");

    property p_flagf_off;
        @(posedge clk) disable iff (sys_rst)
        !s_q.flagf && s_q.fin_set == DISABLE_SET |=> !s_q.flagf;
    endproperty
    a_flagf_off: assert property (p_flagf_off) else $error("final flag set while disabled");

    property p_flagf_clr;
        @(posedge clk) disable iff (sys_rst)
        $fell(s_q.flagf) |-> $past(s_q.rem) > $past(s_q.fin_clr);
    endproperty
    a_flagf_clr: assert property (p_flagf_clr) else $error("final flag cleared early");

    property p_soc_hold;
        @(posedge clk) disable iff (sys_rst)
        s_q.hold_en && s_q.dsg && soc_calc[7:0] > s_q.soc |=> $stable(s_q.soc);
    endproperty
    a_soc_hold: assert property (p_soc_hold) else $error("soc rose while held");

    property p_mode_stat;
        @(posedge clk) disable iff (sys_rst)
        avs_read && avs_address == `SFL_OFS_STATUS && avs_waitrequest
            |=> avs_readdata[`SFL_ST_MODE_BIT] == $past(s_q.load_mode);
    endproperty
    a_mode_stat: assert property (p_mode_stat) else $error("load mode status mismatch");

    property p_user_rate;
        @(posedge clk) disable iff (sys_rst)
        s_q.load_sel == SFL_SEL_USER ##1 s_q.load_sel == SFL_SEL_USER |-> s_q.rate == $past(s_q.urate);
    endproperty
    a_user_rate: assert property (p_user_rate) else $error("user rate not selected");

    property p_undef_sel;
        @(posedge clk) disable iff (sys_rst)
        (s_q.load_sel == 3'h5 || s_q.load_sel == 3'h7) |-> rate_sel == pres_avg;
    endproperty
    a_undef_sel: assert property (p_undef_sel) else $error("undefined selector not default");

    property p_discharge;
        @(posedge clk) disable iff (sys_rst)
        cc_valid && cc_charge < 0 && s_q.nom_rem > 0 |=> s_q.nom_rem < $past(s_q.nom_rem);
    endproperty
    a_discharge: assert property (p_discharge) else $error("discharge not integrated");

    property p_bus_answer;
        @(posedge clk) disable iff (sys_rst)
        req |-> ##[0:1] !avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

endmodule

// >>> tb/sfl_host_model.sv
`timescale 1ns/1ps
module sfl_host_model (
    input  wire logic        clk,
    output logic [7:0]       avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic [31:0]      avs_writedata,
    output logic [3:0]       avs_byteenable,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest,
    output logic             hang
);
    initial begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF;
        hang = 1'b0;
    end

    // Request held until waitrequest is seen low at a rising edge
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) hang <= 1'b1;
    endtask
endmodule

// >>> tb/soc_flag_and_load_model_select_tb_top.sv
`timescale 1ns/1ps
`include "sfl_params.svh"
module soc_flag_and_load_model_select_tb_top
    import sfl_pkg::*;
;
    logic               clk;
    logic               sys_rst;
    logic               cc_valid;
    logic signed [15:0] cc_charge;
    logic signed [15:0] avg_current;
    logic [7:0]         adr;
    logic               rd_en;
    logic               wr_en;
    logic [31:0]        wdat;
    logic [3:0]         be;
    logic [31:0]        rdat;
    logic               wreq;
    logic               flag1;
    logic               flagf;
    logic               irq;
    logic               hang;
    logic [31:0]        q;
    int                 err_total;
    int                 check_count;
    logic signed [15:0] dl[6] = '{16'sh01F4, -16'sh0168, 16'sh0014, 16'sh0014, -16'sh006E, 16'sh0028};
    logic [1:0]         ef[6] = '{2'b00, 2'b10, 2'b10, 2'b00, 2'b11, 2'b10};
    logic [2:0]         sl[6] = '{3'h0, 3'h1, 3'h4, 3'h6, 3'h5, 3'h7};
    logic [15:0]        ex[6] = '{16'h00C8, 16'h00C8, 16'h012C, 16'h0123, 16'h00C8, 16'h00C8};

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    sfl_top #(.SEC_CYCLES(8)) i_sfl_top (.clk(clk), .sys_rst(sys_rst), .avs_address(adr), .avs_read(rd_en),
        .avs_write(wr_en), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
        .avs_waitrequest(wreq), .cc_valid(cc_valid), .cc_charge(cc_charge), .avg_current(avg_current),
        .initial_low_charge_flag(flag1), .final_low_charge_flag(flagf), .irq(irq));
    sfl_host_model i_sfl_host_model (.clk(clk), .avs_address(adr), .avs_read(rd_en), .avs_write(wr_en),
        .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wreq), .hang(hang));

    // ----------------------------------------------------------------
    // Access and compare helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, s, e);
        end
    endtask
    task automatic rd(input logic [7:0] a);
        i_sfl_host_model.acc(1'b0, a, 32'h0000_0000, q);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_sfl_host_model.acc(1'b1, a, d, q);
    endtask
    task automatic cc(input logic signed [15:0] c);
        @(posedge clk);
        cc_valid <= 1'b1;
        cc_charge <= c;
        @(posedge clk);
        cc_valid <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge hang) begin
        err_total++;
        stop_test();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        cc_valid = 1'b0;
        cc_charge = 16'sh0000;
        avg_current = -16'sh00C8;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        rd(`SFL_OFS_CTRL);
        chk(q, 32'h0000_0010);
        rd(8'h44);
        chk(q, 32'h0000_0000);
        rd(`SFL_OFS_INI_SET);
        chk(q, 32'h0000_0096);
        $display("reset test done");
        wr(`SFL_OFS_QMAX, 32'h0000_01F4 * 2);
        wr(`SFL_OFS_IRQ_EN, 32'h0000_0003);
        for (int i = 0; i < 6; i++) begin
            cc(dl[i]);
            chk({30'h0, flag1, flagf}, {30'h0, ef[i]});
        end
        rd(`SFL_OFS_RESULT);
        chk(q, 32'h03E8_0069);
        rd(`SFL_OFS_NOMINAL);
        chk(q, 32'h03E8_0069);
        rd(`SFL_OFS_IRQ_STAT);
        chk(q & 32'h0000_0003, 32'h0000_0003);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(`SFL_OFS_IRQ_CLR, 32'h0000_0007);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(`SFL_OFS_FIN_SET, 32'h0000_FFFF);
        cc(-16'sh003C);
        chk({30'h0, flag1, flagf}, 32'h0000_0002);
        wr(`SFL_OFS_IRQ_EN, 32'h0000_0001);
        wr(`SFL_OFS_FIN_SET, 32'h0000_004B);
        cc(-16'sh000A);
        chk({30'h0, flag1, flagf}, 32'h0000_0003);
        rd(`SFL_OFS_IRQ_STAT);
        chk(q & 32'h0000_0003, 32'h0000_0002);
        chk({31'h0, irq}, 32'h0000_0000);
        $display("flag and irq test done");
        wr(`SFL_OFS_CTRL, 32'h0000_0110);
        cc(16'sh0064);
        rd(`SFL_OFS_STATUS);
        chk(q[15:8], 32'h0000_0003);
        wr(`SFL_OFS_CTRL, 32'h0000_0011);
        cc(16'sh000A);
        rd(`SFL_OFS_STATUS);
        chk(q[15:8], 32'h0000_000E);
        chk(q[2], 32'h0000_0001);
        $display("hold test done");
        wr(`SFL_OFS_DCAP, 32'h0000_05DC);
        wr(`SFL_OFS_URATE, 32'h0000_0123);
        for (int i = 0; i < 6; i++) begin
            wr(`SFL_OFS_CTRL, {25'h0, sl[i], 4'h0});
            repeat (20) @(posedge clk);
            rd(`SFL_OFS_LOAD);
            chk(q[15:0], ex[i]);
        end
        rd(`SFL_OFS_STATUS);
        chk(q[2], 32'h0000_0000);
        avg_current <= -16'sh0190;
        wr(`SFL_OFS_CTRL, 32'h0000_0020);
        repeat (20) @(posedge clk);
        rd(`SFL_OFS_LOAD);
        chk(q[15:0], 32'h0000_0190);
        $display("load select test done");
        stop_test();
    end
endmodule
